// ---- hw/dru_top.sv ----
/*
 * Two-wire bus slave of a quad 12-bit DAC: sequential write, read-back of
 * input and stored copies, deferred output transfer and busy flag.
 * Assumes bus pins, strobe and pull-ups outside; sda is open drain.
 */
// How it works
// - read direction returns, channel by channel, the input register, then its stored copy
// - sequential write fills channels from select bits up to last
// - at most ten bytes per sequential write; later bytes ignored
// - channel codes are 12-bit unsigned, all ones is full scale
// - defer bit and strobe both high: output register keeps value
// - strobe falling edge copies input registers to output registers
// - defer bit or strobe low: new code passes straight to output
// - defer bit affects own channel; strobe and broadcast update all
// - while stored copy is written, flag low and commands discarded
`timescale 1ns/1ns
`include "dru_defs.svh"
module dru_top #(
    parameter logic [6:0] DEV_ADDR = 7'h4A, // arbitrary value
    parameter int unsigned NVM_WRITE_CYCLES = `DRU_NVM_WRITE_CYCLES
) (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n_out,
    input wire logic load_strobe_n_in,
    output logic nvm_ready_flag_out,
    output dru_pkg::dru_codes_t dac_code_out
);
    logic [2:0] scl_s_reg, sda_s_reg, load_strobe_n_s_reg;
    logic scl_f_reg, sda_f_reg, load_strobe_n_f_reg, scl_p_reg, sda_p_reg, load_strobe_n_p_reg;
    dru_pkg::dru_state_t state_reg;
    logic [3:0] bit_cnt_reg, byte_cnt_reg, rd_ptr_reg, hi_reg;
    logic [7:0] shift_reg, tx_reg;
    logic rd_mode_reg, gc_reg, seq_reg, output_transfer_defer_bit_reg, pend_reg, ready_reg, oe_n_reg;
    logic [2:0] ch_reg;
    logic [31:0] busy_cnt_reg;
    dru_pkg::dru_codes_t in_reg, out_reg, nvm_reg;
    wire dru_pkg::dru_codes_t in_next, out_next, nvm_next;

    // three-stage sync; level moves once stages two and three agree
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            scl_s_reg <= 3'h7;
            sda_s_reg <= 3'h7;
            load_strobe_n_s_reg <= 3'h7;
        end else begin
            scl_s_reg <= {scl_s_reg[1:0], scl_in};
            sda_s_reg <= {sda_s_reg[1:0], sda_in};
            load_strobe_n_s_reg <= {load_strobe_n_s_reg[1:0], load_strobe_n_in};
        end
    end
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            {scl_f_reg, sda_f_reg, load_strobe_n_f_reg} <= 3'h7;
            {scl_p_reg, sda_p_reg, load_strobe_n_p_reg} <= 3'h7;
        end else begin
            if (scl_s_reg[1] == scl_s_reg[2]) scl_f_reg <= scl_s_reg[2];
            if (sda_s_reg[1] == sda_s_reg[2]) sda_f_reg <= sda_s_reg[2];
            if (load_strobe_n_s_reg[1] == load_strobe_n_s_reg[2]) load_strobe_n_f_reg <= load_strobe_n_s_reg[2];
            {scl_p_reg, sda_p_reg, load_strobe_n_p_reg} <= {scl_f_reg, sda_f_reg, load_strobe_n_f_reg};
        end
    end

    wire dru_pkg::dru_bus_ev_t ev;
    assign ev.start = sda_p_reg & ~sda_f_reg & scl_f_reg & scl_p_reg;
    assign ev.stop = ~sda_p_reg & sda_f_reg & scl_f_reg & scl_p_reg;
    assign ev.rise = scl_f_reg & ~scl_p_reg;
    assign ev.fall = ~scl_f_reg & scl_p_reg;
    assign ev.sda = sda_f_reg;

    wire st_rx = (state_reg == dru_pkg::DRU_RX);
    wire st_ack = (state_reg == dru_pkg::DRU_ACK);
    wire st_tx = (state_reg == dru_pkg::DRU_TX);
    wire st_rack = (state_reg == dru_pkg::DRU_RACK);
    wire byte_done = st_rx & ev.fall & (bit_cnt_reg == 4'h8);
    wire is_addr = (byte_cnt_reg == 4'h0);
    wire addr_hit = (shift_reg[7:1] == DEV_ADDR);
    wire gc_hit = (shift_reg[7:1] == `DRU_GC_ADDR) & ~shift_reg[0];
    wire busy = ~ready_reg;
    wire ack_now = is_addr ? (~busy & (addr_hit | gc_hit)) : 1'b1;
    wire data_byte = byte_done & ~is_addr & ~rd_mode_reg;
    wire cmd_byte = data_byte & (byte_cnt_reg == 4'h1);
    wire seq_take = cmd_byte & ~gc_reg & (shift_reg[7:3] == `DRU_CMD_SEQ_WRITE);
    wire gc_upd = cmd_byte & gc_reg & (shift_reg == `DRU_GC_UPDATE);
    // only bytes two through nine carry codes; channel past last ignored
    wire code_byte = data_byte & seq_reg & (byte_cnt_reg >= 4'h2)
                   & (byte_cnt_reg < `DRU_SEQ_MAX_BYTES) & ~ch_reg[2];
    wire hi_wr = code_byte & ~byte_cnt_reg[0];
    wire ch_wr = code_byte & byte_cnt_reg[0];
    wire [1:0] wch = ch_reg[1:0];
    wire dru_pkg::dru_code_t wr_code = {hi_reg, shift_reg};
    wire defer = output_transfer_defer_bit_reg & load_strobe_n_f_reg;
    wire load_strobe_n_fall = load_strobe_n_p_reg & ~load_strobe_n_f_reg;
    wire rack_nack = st_rack & ev.rise & ev.sda;
    wire tx_load = (st_ack & ev.fall & rd_mode_reg) | (st_rack & ev.fall);
    wire dru_pkg::dru_code_t rd_code = rd_ptr_reg[1] ? nvm_reg[rd_ptr_reg[3:2]]
                                                     : in_reg[rd_ptr_reg[3:2]];
    wire [7:0] rd_byte = rd_ptr_reg[0] ? rd_code[7:0] : {ready_reg, 3'h0, rd_code[11:8]};

    // bus state machine
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_reg <= dru_pkg::DRU_IDLE;
        end else if (ev.stop) begin
            state_reg <= dru_pkg::DRU_IDLE;
        end else if (ev.start) begin
            state_reg <= dru_pkg::DRU_RX;
        end else begin
            case (state_reg)
                dru_pkg::DRU_RX: if (byte_done) begin
                    state_reg <= ack_now ? dru_pkg::DRU_ACK : dru_pkg::DRU_IDLE;
                end
                dru_pkg::DRU_ACK: if (ev.fall) begin
                    state_reg <= rd_mode_reg ? dru_pkg::DRU_TX : dru_pkg::DRU_RX;
                end
                dru_pkg::DRU_TX: if (ev.fall && bit_cnt_reg == 4'h7) begin
                    state_reg <= dru_pkg::DRU_RACK;
                end
                dru_pkg::DRU_RACK: begin
                    if (rack_nack) state_reg <= dru_pkg::DRU_IDLE;
                    else if (ev.fall) state_reg <= dru_pkg::DRU_TX;
                end
                default: state_reg <= state_reg;
            endcase
        end
    end

    // bit and byte counters, receive and transmit shifters
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            bit_cnt_reg <= 4'h0;
            byte_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            tx_reg <= 8'hFF;
        end else if (ev.start) begin
            bit_cnt_reg <= 4'h0;
            byte_cnt_reg <= 4'h0;
        end else begin
            if (st_rx && ev.rise) shift_reg <= {shift_reg[6:0], ev.sda};
            if (st_rx && ev.rise) bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if ((st_ack && ev.fall) || tx_load) bit_cnt_reg <= 4'h0;
            if (st_tx && ev.fall) bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (byte_done && byte_cnt_reg != `DRU_BYTE_CNT_MAX) begin
                byte_cnt_reg <= byte_cnt_reg + 4'h1;
            end
            if (tx_load) tx_reg <= rd_byte;
            else if (st_tx && ev.fall) tx_reg <= {tx_reg[6:0], 1'b1};
        end
    end

    // open-drain data drive; enable low pulls the line low
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            oe_n_reg <= 1'b1;
        end else if (ev.stop || ev.start || rack_nack) begin
            oe_n_reg <= 1'b1;
        end else if (byte_done) begin
            oe_n_reg <= ~ack_now;
        end else if (tx_load) begin
            oe_n_reg <= rd_byte[7];
        end else if (st_tx && ev.fall) begin
            oe_n_reg <= (bit_cnt_reg == 4'h7) ? 1'b1 : tx_reg[6];
        end else if (st_ack && ev.fall) begin
            oe_n_reg <= 1'b1;
        end
    end

    // transaction mode and sequential channel pointer
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rd_mode_reg <= 1'b0;
            gc_reg <= 1'b0;
            seq_reg <= 1'b0;
            output_transfer_defer_bit_reg <= 1'b0;
            ch_reg <= 3'h0;
            hi_reg <= 4'h0;
            rd_ptr_reg <= 4'h0;
        end else if (ev.stop || ev.start || rack_nack) begin
            rd_mode_reg <= 1'b0;
            seq_reg <= 1'b0;
            rd_ptr_reg <= 4'h0;
        end else begin
            if (byte_done && is_addr) begin
                rd_mode_reg <= shift_reg[0] & addr_hit & ack_now;
                gc_reg <= gc_hit;
            end
            if (seq_take) begin
                seq_reg <= 1'b1;
                ch_reg <= {1'b0, shift_reg[2:1]};
                output_transfer_defer_bit_reg <= shift_reg[0];
            end
            if (hi_wr) hi_reg <= shift_reg[3:0];
            if (ch_wr) ch_reg <= ch_reg + 3'h1;
            if (tx_load) rd_ptr_reg <= rd_ptr_reg + 4'h1;
        end
    end

    // per-channel next values of input, output and stored copy registers
    for (genvar i = 0; i < 4; i++) begin : g_ch
        wire hit = ch_wr & (wch == 2'(i));
        assign in_next[i] = hit ? wr_code : in_reg[i];
        assign nvm_next[i] = hit ? wr_code : nvm_reg[i];
        assign out_next[i] = (load_strobe_n_fall | gc_upd) ? in_next[i]
                           : (hit & ~defer) ? wr_code : out_reg[i];
    end
    // whole vectors in one process, so each register has a single writer
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            in_reg <= 48'h0;
            out_reg <= 48'h0;
            nvm_reg <= 48'h0;
        end else begin
            in_reg <= in_next;
            out_reg <= out_next;
            nvm_reg <= nvm_next;
        end
    end

    // stored-copy write timer started by the stop that ends the write
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pend_reg <= 1'b0;
            ready_reg <= 1'b1;
            busy_cnt_reg <= 32'h0;
        end else if (ev.stop && pend_reg) begin
            pend_reg <= 1'b0;
            ready_reg <= 1'b0;
            busy_cnt_reg <= NVM_WRITE_CYCLES;
        end else begin
            if (ch_wr) pend_reg <= 1'b1;
            if (busy_cnt_reg != 32'h0) busy_cnt_reg <= busy_cnt_reg - 32'h1;
            if (busy_cnt_reg == 32'h1) ready_reg <= 1'b1;
        end
    end

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) sda_out <= 1'b0;
        else sda_out <= 1'b0;
    end
    assign sda_oe_n_out = oe_n_reg;
    assign nvm_ready_flag_out = ready_reg;
    assign dac_code_out = out_reg;

    a_busy_no_ack: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (busy && byte_done && is_addr) |=> sda_oe_n_out) else $error("ack while busy");
    a_strobe_copy: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        load_strobe_n_fall |=> (dac_code_out == in_reg)) else $error("strobe copy missed");
    a_defer_hold: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (ch_wr && defer && !load_strobe_n_fall) |=> (dac_code_out[$past(wch)] ==
        $past(dac_code_out[wch]))) else $error("deferred output changed");
    a_pass_through: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (ch_wr && !defer) |=> (dac_code_out[$past(wch)] == $past(wr_code)))
        else $error("code not passed through");
    a_byte_limit: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        ch_wr |-> (byte_cnt_reg < 4'hA && byte_cnt_reg > 4'h2)) else $error("byte limit");
    a_start_chan: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        seq_take |=> (ch_reg == {1'b0, $past(shift_reg[2:1])})) else $error("start chan");
    a_read_exit: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (ev.stop || rack_nack) |=> (!rd_mode_reg && state_reg == dru_pkg::DRU_IDLE))
        else $error("read mode not left");
    a_read_order: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (tx_load && rd_ptr_reg == 4'h2) |=> (tx_reg[3:0] == nvm_reg[0][11:8]))
        else $error("read order");
    c_seq_write: cover property (@(posedge clock_in) ch_wr ##[1:1000] ev.stop);
    c_read_byte: cover property (@(posedge clock_in) tx_load && rd_mode_reg);
    c_strobe: cover property (@(posedge clock_in) load_strobe_n_fall && dac_code_out != in_reg);
    c_broadcast: cover property (@(posedge clock_in) gc_upd);
endmodule : dru_top

// ---- hw/dru_defs.svh ----
/*
 * Constants of the DAC command interpreter: command codes, limits, timing.
 * Assumes inclusion by name from the design files; definitions only.
 */
`ifndef DRU_DEFS_SVH
`define DRU_DEFS_SVH

`define DRU_GC_ADDR 7'h00
`define DRU_GC_UPDATE 8'h08
`define DRU_CMD_SEQ_WRITE 5'h0A
`define DRU_SEQ_MAX_BYTES 4'hA
`define DRU_BYTE_CNT_MAX 4'hF
`define DRU_CODE_FULL_SCALE 12'hFFF
`define DRU_CLK_PERIOD_NS 10
`define DRU_NVM_WRITE_NS 25000000
`define DRU_NVM_WRITE_CYCLES (`DRU_NVM_WRITE_NS / `DRU_CLK_PERIOD_NS)

`endif

// ---- hw/dru_pkg.sv ----
/*
 * Types of the DAC command interpreter.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package dru_pkg;
    typedef logic [11:0] dru_code_t;
    typedef dru_code_t [3:0] dru_codes_t;
    typedef enum logic [4:0] {
        DRU_IDLE = 5'h01,
        DRU_RX = 5'h02,
        DRU_ACK = 5'h04,
        DRU_TX = 5'h08,
        DRU_RACK = 5'h10
    } dru_state_t;
    typedef struct packed {
        logic start;
        logic stop;
        logic rise;
        logic fall;
        logic sda;
    } dru_bus_ev_t;
endpackage : dru_pkg

// ---- verif/dru_master.sv ----
/* Bus master and load strobe driver model for the DAC slave.
   Assumes pull-ups on both wires, resolved in the bench top. */
`timescale 1ns/1ns
module dru_master (
    input wire logic clock_in,
    input wire logic sda_in,
    output logic scl_pull_out,
    output logic sda_pull_out,
    output logic load_strobe_n_out
);
    initial begin
        scl_pull_out = 1'b0;
        sda_pull_out = 1'b0;
        load_strobe_n_out = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
    endtask : tick
    task automatic start();
        sda_pull_out <= 1'b1;
        tick(10);
        scl_pull_out <= 1'b1;
        tick(10);
    endtask : start
    task automatic stop();
        sda_pull_out <= 1'b1;
        tick(10);
        scl_pull_out <= 1'b0;
        tick(10);
        sda_pull_out <= 1'b0;
        tick(20);
    endtask : stop
    // data moves only while scl is low
    task automatic bit_io(input logic b, output logic r);
        sda_pull_out <= ~b;
        tick(10);
        scl_pull_out <= 1'b0;
        tick(10);
        r = sda_in;
        tick(10);
        scl_pull_out <= 1'b1;
        tick(10);
    endtask : bit_io
    // bus address is known up front, never taken from read mode
    task automatic byte_tx(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask : byte_tx
    task automatic byte_rx(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(last, r);
    endtask : byte_rx
    task automatic strobe(input logic lvl);
        load_strobe_n_out <= lvl;
        tick(10);
    endtask : strobe
endmodule : dru_master

// ---- verif/dac_read_and_output_update_tb_top.sv ----
/* Self-checking bench of the DAC bus slave: writes, deferral, update, read.
   Assumes the master model drives both wires through pull-ups. */
`timescale 1ns/1ns
`include "dru_defs.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
    $display("unexpected %s: expected %h seen %h", nm, e, g); end end
module dac_read_and_output_update_tb_top;
    localparam logic [6:0] ADDR = 7'h4A;
    logic clock_in;
    logic sys_rst_in;
    logic scl_pull, sda_pull, strobe_n, sda_drv, sda_oe_n, ready, a;
    logic [7:0] d;
    dru_pkg::dru_codes_t codes, va, vb, vc, vd;
    int num_errors = 0;
    int checked = 0;
    wire scl = ~scl_pull;
    wire sda = ~sda_pull & (sda_oe_n | sda_drv);
    dru_top #(.DEV_ADDR(ADDR), .NVM_WRITE_CYCLES(2000)) dut_u (.clock_in(clock_in),
        .sys_rst_in(sys_rst_in), .scl_in(scl), .sda_in(sda), .sda_out(sda_drv),
        .sda_oe_n_out(sda_oe_n), .load_strobe_n_in(strobe_n),
        .nvm_ready_flag_out(ready), .dac_code_out(codes));
    dru_master m_u (.clock_in(clock_in), .sda_in(sda), .scl_pull_out(scl_pull),
        .sda_pull_out(sda_pull), .load_strobe_n_out(strobe_n));
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    task automatic end_of_test();
        $display("checked %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_of_test
    task automatic seq_wr(input logic [1:0] sel, input logic dfr,
                          input dru_pkg::dru_codes_t v, input int extra);
        dru_pkg::dru_code_t w;
        m_u.start();
        m_u.byte_tx({ADDR, 1'b0}, a);
        `CHK("addr ack", 1'b1, a)
        m_u.byte_tx({`DRU_CMD_SEQ_WRITE, sel, dfr}, a);
        for (int c = sel; c < 4 + extra; c++) begin
            // pairs past the last channel carry other codes, so taking one shows
            w = (c < 4) ? v[c] : ~v[c % 4];
            m_u.byte_tx({4'h0, w[11:8]}, a);
            m_u.byte_tx(w[7:0], a);
        end
        m_u.stop();
    endtask : seq_wr
    task automatic chk_codes(input dru_pkg::dru_codes_t e);
        for (int i = 0; i < 4; i++) `CHK("dac code", e[i], codes[i])
    endtask : chk_codes
    task automatic wait_ready();
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 5000) begin
            m_u.tick(1);
            n++;
        end
        `CHK("ready", 1'b1, ready)
    endtask : wait_ready
    task automatic t_direct();
        va = {12'h000, 12'hABC, 12'h123, `DRU_CODE_FULL_SCALE};
        seq_wr(2'b00, 1'b0, va, 1);
        chk_codes(va);
        `CHK("busy", 1'b0, ready)
        m_u.start();
        m_u.byte_tx({ADDR, 1'b0}, a);
        `CHK("busy ack", 1'b0, a)
        m_u.stop();
        wait_ready();
        $display("done t_direct");
    endtask : t_direct
    task automatic t_defer();
        vb = {12'h456, 12'h789, 12'hFED, 12'h001};
        vc = {12'h800, 12'h7FF, 12'h010, 12'h9A5};
        vd = {12'h111, 12'h222, 12'h333, 12'h444};
        seq_wr(2'b00, 1'b1, vb, 0);
        chk_codes(va);
        wait_ready();
        m_u.start();
        m_u.byte_tx({`DRU_GC_ADDR, 1'b0}, a);
        m_u.byte_tx(`DRU_GC_UPDATE, a);
        m_u.stop();
        chk_codes(vb);
        seq_wr(2'b00, 1'b1, vc, 0);
        chk_codes(vb);
        wait_ready();
        m_u.strobe(1'b0);
        chk_codes(vc);
        seq_wr(2'b01, 1'b1, vd, 0);
        chk_codes({vd[3], vd[2], vd[1], vc[0]});
        wait_ready();
        m_u.strobe(1'b1);
        $display("done t_defer");
    endtask : t_defer
    task automatic t_read();
        m_u.start();
        m_u.byte_tx({ADDR, 1'b1}, a);
        `CHK("read ack", 1'b1, a)
        m_u.byte_rx(1'b0, d);
        `CHK("input hi", {4'h8, vc[0][11:8]}, d)
        m_u.byte_rx(1'b0, d);
        `CHK("input lo", vc[0][7:0], d)
        m_u.byte_rx(1'b0, d);
        `CHK("stored hi", {4'h8, vc[0][11:8]}, d)
        m_u.byte_rx(1'b1, d);
        `CHK("stored lo", vc[0][7:0], d)
        m_u.stop();
        m_u.start();
        m_u.byte_tx({ADDR, 1'b0}, a);
        `CHK("ack after read", 1'b1, a)
        m_u.stop();
        $display("done t_read");
    endtask : t_read
    initial begin
        sys_rst_in = 1'b1;
        repeat (3) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        m_u.tick(10);
        `CHK("reset oe_n", 1'b1, sda_oe_n)
        `CHK("reset ready", 1'b1, ready)
        `CHK("reset codes", 48'h0, codes)
        `CHK("sda drive", 1'b0, sda_drv)
        t_direct();
        t_defer();
        t_read();
        end_of_test();
    end
    initial begin
        repeat (60000) @(posedge clock_in);
        num_errors++;
        end_of_test();
    end
endmodule : dac_read_and_output_update_tb_top
